// file: src/pdm_pkg.sv
// Package with the constants and types of the power-down mode controller
// Function
// - Halt instruction with standby select clear enters sleep mode.
// - Halt instruction with standby select set enters standby; clock, CPU, peripherals stop.
// - Sleep halts the CPU right away, registers kept, peripherals keep running.
// - Accepted interrupt ends sleep; masked or source-disabled interrupt leaves sleep in place.
// - DMA address error during sleep ends sleep and starts its exception.
// - Power-on reset from the reset pin ends sleep.
// - Standby ends only by NMI or power-on reset; CPU state and RAM kept.
// - In standby ports hold when float select is 0, float when 1.
// - Standby select cannot be set while the watchdog runs.
// - Port float select cannot be set while the watchdog runs.
// - Bit 5 reads 0, bits 4..0 read 1; software writes them likewise.
// - Control register is 8-bit read/write; bit 7 standby, bit 6 port float.
// - Control register resets to 1f: sleep selected, ports held.
package pdm_pkg;
  localparam int PDM_AW = 32;
  localparam int PDM_DW = 8;
  localparam int PDM_LVL_W = 4;
  localparam logic [PDM_AW-1:0] PDM_CTRL_ADDR = 32'hffff8614;
  localparam logic [PDM_DW-1:0] PDM_CTRL_RST = 8'h1f;
  localparam int PDM_SBY_BIT = 7;
  localparam int PDM_FLT_BIT = 6;
  localparam logic PDM_SBY_RST = 1'h0;
  localparam logic PDM_FLT_RST = 1'h0;
  localparam logic [5:0] PDM_RSV_READ = 6'h1f;
  typedef enum logic [1:0] {PDM_RUN, PDM_SLEEP, PDM_STBY} pdm_mode_t;
  typedef enum logic [1:0] {PDM_CAUSE_NONE, PDM_CAUSE_IRQ, PDM_CAUSE_DMA, PDM_CAUSE_NMI} pdm_cause_t;
endpackage

// file: src/pdm_cfg_if.sv
// Interface carrying the mode selects and watchdog state between core and registers
interface pdm_cfg_if;
  logic standby_select;
  logic port_float_select;
  logic watchdog_run_enable;
  modport regs (output standby_select, output port_float_select, input watchdog_run_enable);
  modport core (input standby_select, input port_float_select, output watchdog_run_enable);
endinterface

// file: src/pdm_regs.sv
// Control register holding standby select and port float select
module pdm_regs (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic por, // Power-on reset from the pin
  input wire logic [pdm_pkg::PDM_AW-1:0] reg_addr, // Register address
  input wire logic [pdm_pkg::PDM_DW-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [pdm_pkg::PDM_DW-1:0] reg_rdata, // Read data, cycle after strobe
  pdm_cfg_if.regs cfg // Selects out, watchdog state in
);
  import pdm_pkg::*;

  logic standby_select_r;
  logic port_float_select_r;
  logic hit;
  logic wdt;
  logic [PDM_DW-1:0] ctrl_val;

  assign hit = reg_addr == PDM_CTRL_ADDR;
  assign wdt = cfg.watchdog_run_enable;
  // Reserved bits are constants, so writes to them go nowhere
  assign ctrl_val = {standby_select_r, port_float_select_r, PDM_RSV_READ};
  assign cfg.standby_select = standby_select_r;
  assign cfg.port_float_select = port_float_select_r;

  // Each bit may clear at any time but may rise only with the watchdog stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      standby_select_r <= PDM_SBY_RST;
      port_float_select_r <= PDM_FLT_RST;
    end else if (por) begin
      standby_select_r <= PDM_SBY_RST;
      port_float_select_r <= PDM_FLT_RST;
    end else if (reg_wr && hit) begin
      standby_select_r <= reg_wdata[PDM_SBY_BIT] & (standby_select_r | ~wdt);
      port_float_select_r <= reg_wdata[PDM_FLT_BIT] & (port_float_select_r | ~wdt);
    end
  end

  // Read data stand for one cycle only; unmapped reads return zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= (reg_rd && hit) ? ctrl_val : 8'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_sby_blocked: assert property (reg_wr && hit && wdt && !standby_select_r && !por |=> !standby_select_r)
    else $error("standby select rose while watchdog ran");
  a_flt_blocked: assert property (reg_wr && hit && wdt && !port_float_select_r && !por |=> !port_float_select_r)
    else $error("port float select rose while watchdog ran");
  a_clear_allowed: assert property (reg_wr && hit && wdt && !reg_wdata[PDM_FLT_BIT] && !por |=> !port_float_select_r)
    else $error("clear of port float select lost under watchdog");
  a_reserved_read: assert property (reg_rd && hit |=> reg_rdata[5:0] == PDM_RSV_READ)
    else $error("reserved bits read wrong");
  a_ctrl_read: assert property (reg_rd && hit |=> reg_rdata[7:6] == {$past(standby_select_r), $past(port_float_select_r)})
    else $error("control bits read wrong");
  a_por_value: assert property (por ##1 reg_rd && hit |=> reg_rdata == PDM_CTRL_RST)
    else $error("control register not at reset value");
endmodule

// file: src/pdm_wake.sv
// Wake qualifier: decides whether and why a power-down mode ends
module pdm_wake (
  input pdm_pkg::pdm_mode_t mode, // Current mode
  input wire logic irq_req, // Interrupt request pending
  input wire logic [pdm_pkg::PDM_LVL_W-1:0] irq_level, // Request priority
  input wire logic irq_src_en, // Enabled at its peripheral
  input wire logic [pdm_pkg::PDM_LVL_W-1:0] cpu_mask, // Mask level from the CPU flags
  input wire logic dma_addr_err, // DMA engine address error
  input wire logic nmi_edge, // Synchronised NMI edge
  output logic wake, // Mode ends this cycle
  output pdm_pkg::pdm_cause_t cause // Exception to start
);
  import pdm_pkg::*;

  logic irq_ok;

  // Equal priority to the mask does not get through
  assign irq_ok = irq_req && irq_src_en && (irq_level > cpu_mask);

  // Standby listens to NMI only; sleep takes NMI, DMA error, then interrupts
  always_comb begin
    wake = 1'b0;
    cause = PDM_CAUSE_NONE;
    unique case (mode)
      PDM_STBY: begin
        if (nmi_edge) begin
          wake = 1'b1;
          cause = PDM_CAUSE_NMI;
        end
      end
      PDM_SLEEP: begin
        if (nmi_edge) begin
          wake = 1'b1;
          cause = PDM_CAUSE_NMI;
        end else if (dma_addr_err) begin
          wake = 1'b1;
          cause = PDM_CAUSE_DMA;
        end else if (irq_ok) begin
          wake = 1'b1;
          cause = PDM_CAUSE_IRQ;
        end
      end
      PDM_RUN: begin
        wake = 1'b0;
      end
    endcase
  end
endmodule

// file: src/pdm_ctrl.sv
// Power-down mode controller top: sleep and standby sequencing with register port
module pdm_ctrl (
  input wire logic clk, // 250 MHz system oscillator
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic [pdm_pkg::PDM_AW-1:0] reg_addr, // Register address
  input wire logic [pdm_pkg::PDM_DW-1:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [pdm_pkg::PDM_DW-1:0] reg_rdata, // Read data, cycle after strobe
  input wire logic sleep_exec, // CPU executed the halt instruction
  input wire logic irq_req, // Interrupt request pending
  input wire logic [pdm_pkg::PDM_LVL_W-1:0] irq_level, // Request priority
  input wire logic irq_src_en, // Request enabled at its peripheral
  input wire logic [pdm_pkg::PDM_LVL_W-1:0] cpu_mask, // Mask level of CPU flags
  input wire logic dma_addr_err, // DMA engine address error
  input wire logic watchdog_run_enable, // Watchdog running
  input wire logic nmi_pin, // NMI pin, asynchronous
  input wire logic reset_pin_n, // Reset pin, asynchronous, active low
  output logic cpu_halt, // CPU stopped, registers held
  output logic clk_run, // System clock enable to clock tree
  output logic periph_run, // Peripheral modules running
  output logic port_hold, // I/O ports latched
  output logic port_float, // I/O port drivers released
  output logic por_out, // Power-on reset to the CPU
  output logic wake_exc, // Start exception handling, one cycle
  output pdm_pkg::pdm_cause_t wake_cause, // Exception kind with wake_exc
  output pdm_pkg::pdm_mode_t mode // Current mode
);
  import pdm_pkg::*;

  logic rst_s1_r;
  logic rst_n_r;
  logic nmi_s1_r;
  logic nmi_s2_r;
  logic nmi_d_r;
  logic res_s1_r;
  logic res_s2_r;
  logic nmi_edge;
  logic por;
  logic wake;
  pdm_cause_t cause;
  pdm_mode_t mode_r;
  pdm_mode_t mode_nxt;
  logic wake_exc_r;
  pdm_cause_t wake_cause_r;
  logic port_float_r;
  logic port_hold_r;

  pdm_cfg_if cfg ();

  // Reset release through two flops so all logic leaves reset on one edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Pin synchronisers; the second stage feeds logic, plus a third NMI flop for the edge
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      nmi_s1_r <= 1'b0;
      nmi_s2_r <= 1'b0;
      nmi_d_r <= 1'b0;
      res_s1_r <= 1'b1;
      res_s2_r <= 1'b1;
    end else begin
      nmi_s1_r <= nmi_pin;
      nmi_s2_r <= nmi_s1_r;
      nmi_d_r <= nmi_s2_r;
      res_s1_r <= reset_pin_n;
      res_s2_r <= res_s1_r;
    end
  end

  // NMI acts on its rising edge, so a held pin wakes only once
  assign nmi_edge = nmi_s2_r && !nmi_d_r;
  assign por = !res_s2_r;
  assign por_out = por;
  assign cfg.watchdog_run_enable = watchdog_run_enable;

  pdm_regs u_regs (
    .clk(clk),
    .rst_n(rst_n_r),
    .por(por),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .cfg(cfg)
  );

  pdm_wake u_wake (
    .mode(mode_r),
    .irq_req(irq_req),
    .irq_level(irq_level),
    .irq_src_en(irq_src_en),
    .cpu_mask(cpu_mask),
    .dma_addr_err(dma_addr_err),
    .nmi_edge(nmi_edge),
    .wake(wake),
    .cause(cause)
  );

  // Next mode; the reset pin overrides every other event
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      PDM_RUN: begin
        if (sleep_exec && cfg.standby_select) begin
          mode_nxt = PDM_STBY;
        end else if (sleep_exec) begin
          mode_nxt = PDM_SLEEP;
        end
      end
      PDM_SLEEP: begin
        if (wake) begin
          mode_nxt = PDM_RUN;
        end
      end
      PDM_STBY: begin
        if (wake) begin
          mode_nxt = PDM_RUN;
        end
      end
    endcase
    if (por) begin
      mode_nxt = PDM_RUN;
    end
  end

  // Mode register
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r <= PDM_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Exception start pulse; a reset wake runs the reset vector instead
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wake_exc_r <= 1'b0;
      wake_cause_r <= PDM_CAUSE_NONE;
    end else if (wake && !por && mode_r != PDM_RUN) begin
      wake_exc_r <= 1'b1;
      wake_cause_r <= cause;
    end else begin
      wake_exc_r <= 1'b0;
      wake_cause_r <= PDM_CAUSE_NONE;
    end
  end

  // Port state follows the float select each cycle while the next mode is standby
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      port_float_r <= 1'b0;
      port_hold_r <= 1'b0;
    end else begin
      port_float_r <= (mode_nxt == PDM_STBY) && cfg.port_float_select;
      port_hold_r <= (mode_nxt == PDM_STBY) && !cfg.port_float_select;
    end
  end

  // Clock and peripherals stop only in standby; CPU stops in both modes
  assign cpu_halt = mode_r != PDM_RUN;
  assign clk_run = mode_r != PDM_STBY;
  assign periph_run = mode_r != PDM_STBY;
  assign port_float = port_float_r;
  assign port_hold = port_hold_r;
  assign wake_exc = wake_exc_r;
  assign wake_cause = wake_cause_r;
  assign mode = mode_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_r);

  sequence s_run_halt;
    mode_r == PDM_RUN && sleep_exec && !por;
  endsequence

  sequence s_stby_nmi;
    mode_r == PDM_STBY && nmi_edge && !por;
  endsequence

  sequence s_resumed(pdm_cause_t c);
    mode_r == PDM_RUN && wake_exc && wake_cause == c ##1 !wake_exc;
  endsequence

  a_sleep_entry: assert property (s_run_halt ##0 !cfg.standby_select |=> mode_r == PDM_SLEEP)
    else $error("halt with standby clear did not sleep");
  a_stby_entry: assert property (s_run_halt ##0 cfg.standby_select |=> !clk_run && !periph_run && cpu_halt)
    else $error("standby did not stop clock and peripherals");
  a_sleep_status: assert property (mode_r == PDM_SLEEP |-> cpu_halt && periph_run && clk_run)
    else $error("sleep status outputs wrong");
  a_irq_wake: assert property (mode_r == PDM_SLEEP && irq_req && irq_src_en && irq_level > cpu_mask
      && !dma_addr_err && !nmi_edge && !por |=> s_resumed(PDM_CAUSE_IRQ))
    else $error("accepted interrupt did not end sleep");
  a_irq_masked: assert property (mode_r == PDM_SLEEP && (!irq_req || !irq_src_en || irq_level <= cpu_mask)
      && !dma_addr_err && !nmi_edge && !por |=> mode_r == PDM_SLEEP && !wake_exc)
    else $error("unacceptable interrupt ended sleep");
  a_dma_wake: assert property (mode_r == PDM_SLEEP && dma_addr_err && !nmi_edge && !por
      |=> s_resumed(PDM_CAUSE_DMA))
    else $error("address error did not end sleep");
  a_por_wake: assert property ($fell(reset_pin_n) && mode_r != PDM_RUN ##2 1 |=> mode_r == PDM_RUN && !wake_exc)
    else $error("reset pin did not end power-down");
  a_stby_stays: assert property (mode_r == PDM_STBY && !nmi_edge && !por |=> mode_r == PDM_STBY)
    else $error("standby left without NMI or reset");
  a_nmi_resume: assert property (s_stby_nmi |=> clk_run ##0 s_resumed(PDM_CAUSE_NMI))
    else $error("NMI did not resume from standby");
  a_port_state: assert property (s_run_halt ##0 cfg.standby_select
      |=> port_float == $past(cfg.port_float_select) && port_hold == !$past(cfg.port_float_select))
    else $error("port state in standby wrong");
endmodule

// file: verif/pdm_cpu_model.sv
// Model of the CPU core, interrupt controller and watchdog facing the controller
module pdm_cpu_model (
  input wire logic clk, // System clock
  output logic sleep_exec, // Halt instruction executed
  output logic irq_req, // Interrupt pending
  output logic [pdm_pkg::PDM_LVL_W-1:0] irq_level, // Request priority
  output logic irq_src_en, // Enabled at its peripheral
  output logic [pdm_pkg::PDM_LVL_W-1:0] cpu_mask, // CPU mask level
  output logic dma_addr_err, // DMA engine address error
  output logic watchdog_run_enable, // Watchdog running
  output logic nmi_pin, // NMI pin
  output logic reset_pin_n // Reset pin, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  import pdm_pkg::*;

  // Idle levels: nothing pending, watchdog stopped, reset pin released
  initial begin
    sleep_exec = 1'b0;
    irq_req = 1'b0;
    irq_level = 4'h0;
    irq_src_en = 1'b1;
    cpu_mask = 4'h0;
    dma_addr_err = 1'b0;
    watchdog_run_enable = 1'b0;
    nmi_pin = 1'b0;
    reset_pin_n = 1'b1;
  end

  // Halt instruction, a one-cycle pulse
  task automatic halt();
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
  endtask

  // One-cycle interrupt and/or DMA error event; mask level stays afterwards
  task automatic poke(input logic req, input logic [PDM_LVL_W-1:0] lvl, input logic [PDM_LVL_W-1:0] msk,
                      input logic en, input logic dma);
    @(posedge clk);
    irq_req <= req;
    irq_level <= lvl;
    cpu_mask <= msk;
    irq_src_en <= en;
    dma_addr_err <= dma;
    @(posedge clk);
    irq_req <= 1'b0;
    dma_addr_err <= 1'b0;
  endtask

  // Watchdog run state; software stops it before asking for standby
  task automatic wdt(input logic on);
    @(posedge clk);
    watchdog_run_enable <= on;
  endtask

  // Level changes on the asynchronous pins
  task automatic nmi(input logic v);
    @(posedge clk);
    nmi_pin <= v;
  endtask

  task automatic pin(input logic v);
    @(posedge clk);
    reset_pin_n <= v;
  endtask
endmodule

// file: verif/pdm_ctrl_tb.sv
// Self-checking testbench of the power-down mode controller
module pdm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pdm_pkg::*;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
  logic clk, rstn, reg_wr, reg_rd;
  logic [PDM_AW-1:0] reg_addr;
  logic [PDM_DW-1:0] reg_wdata, reg_rdata;
  logic sleep_exec, irq_req, irq_src_en, dma_addr_err, watchdog_run_enable, nmi_pin, reset_pin_n;
  logic [PDM_LVL_W-1:0] irq_level, cpu_mask;
  logic cpu_halt, clk_run, periph_run, port_hold, port_float, por_out, wake_exc;
  pdm_cause_t wake_cause;
  pdm_mode_t mode;
  int err_total = 0;
  int n_checks = 0;

  pdm_ctrl dut_u (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_exec, .irq_req,
    .irq_level, .irq_src_en, .cpu_mask, .dma_addr_err, .watchdog_run_enable, .nmi_pin, .reset_pin_n,
    .cpu_halt, .clk_run, .periph_run, .port_hold, .port_float, .por_out, .wake_exc, .wake_cause, .mode);
  pdm_cpu_model cpu_u (.clk, .sleep_exec, .irq_req, .irq_level, .irq_src_en, .cpu_mask, .dma_addr_err,
    .watchdog_run_enable, .nmi_pin, .reset_pin_n);

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Register write, one strobe cycle
  task automatic wr(input logic [PDM_AW-1:0] a, input logic [PDM_DW-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Register read; data only stand in the cycle after the strobe
  task automatic rd(input logic [PDM_AW-1:0] a, input logic [PDM_DW-1:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  // Mode, run decodes, exception pulse and port state {hold, float}
  task automatic chk_mode(input pdm_mode_t m, input logic h, input logic run, input logic x, input logic [1:0] p);
    `CHK(mode, m)
    `CHK(cpu_halt, h)
    `CHK(clk_run, run)
    `CHK(periph_run, run)
    `CHK(wake_exc, x)
    `CHK({port_hold, port_float}, p)
  endtask

  // Bounded wait for the exception pulse of a wake
  task automatic wait_exc(input pdm_cause_t c);
    int i;
    for (i = 0; i < 8 && wake_exc !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK(wake_cause, c)
    chk_mode(PDM_RUN, 1'b0, 1'b1, 1'b1, 2'h0);
    // A wake that never came is a mismatch of its own
    if (i == 8) begin
      err_total++;
      print_verdict();
    end
  endtask

  // Reset pin pulse: back to run with no exception, register bits cleared
  task automatic pin_reset();
    int i;
    cpu_u.pin(1'b0);
    // Sample after the edge settles, not in its own time step
    for (i = 0; i < 8 && por_out !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1 chk_mode(PDM_RUN, 1'b0, 1'b1, 1'b0, 2'h0);
    `CHK(por_out, 1'b1)
    // Read while the pin is still low: register already back at reset value
    rd(PDM_CTRL_ADDR, PDM_CTRL_RST);
    cpu_u.pin(1'b1);
    repeat (4) @(posedge clk);
    if (i == 8) begin
      err_total++;
      print_verdict();
    end
  endtask

  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (2) @(posedge clk);
    #1 chk_mode(PDM_RUN, 1'b0, 1'b1, 1'b0, 2'h0);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    // Register map, unmapped place and watchdog blocking
    rd(PDM_CTRL_ADDR, PDM_CTRL_RST);
    wr(PDM_CTRL_ADDR + 32'h4, 8'hdf);
    rd(PDM_CTRL_ADDR, 8'h1f);
    rd(PDM_CTRL_ADDR + 32'h4, 8'h00);
    wr(PDM_CTRL_ADDR, 8'hdf);
    rd(PDM_CTRL_ADDR, 8'hdf);
    wr(PDM_CTRL_ADDR, 8'h9f);
    cpu_u.wdt(1'b1);
    wr(PDM_CTRL_ADDR, 8'h5f);
    rd(PDM_CTRL_ADDR, 8'h1f);
    wr(PDM_CTRL_ADDR, 8'hdf);
    rd(PDM_CTRL_ADDR, 8'h1f);
    cpu_u.wdt(1'b0);
    // Sleep: equal priority and source-disabled requests are refused
    cpu_u.halt();
    #1 chk_mode(PDM_SLEEP, 1'b1, 1'b1, 1'b0, 2'h0);
    cpu_u.poke(1'b1, 4'h3, 4'h3, 1'b1, 1'b0);
    #1 chk_mode(PDM_SLEEP, 1'b1, 1'b1, 1'b0, 2'h0);
    cpu_u.poke(1'b1, 4'h5, 4'h3, 1'b0, 1'b0);
    #1 chk_mode(PDM_SLEEP, 1'b1, 1'b1, 1'b0, 2'h0);
    cpu_u.poke(1'b1, 4'h4, 4'h3, 1'b1, 1'b0);
    #1 `CHK(wake_cause, PDM_CAUSE_IRQ)
    chk_mode(PDM_RUN, 1'b0, 1'b1, 1'b1, 2'h0);
    cpu_u.halt();
    cpu_u.poke(1'b0, 4'h0, 4'h0, 1'b1, 1'b1);
    #1 `CHK(wake_cause, PDM_CAUSE_DMA)
    chk_mode(PDM_RUN, 1'b0, 1'b1, 1'b1, 2'h0);
    @(posedge clk);
    #1 `CHK(wake_exc, 1'b0)
    cpu_u.halt();
    pin_reset();
    // Standby with ports held, then floated; only NMI or the reset pin leave it
    for (int f = 0; f < 2; f++) begin
      wr(PDM_CTRL_ADDR, f ? 8'hdf : 8'h9f);
      cpu_u.halt();
      #1 chk_mode(PDM_STBY, 1'b1, 1'b0, 1'b0, f ? 2'h1 : 2'h2);
      cpu_u.poke(1'b1, 4'hf, 4'h0, 1'b1, 1'b1);
      #1 chk_mode(PDM_STBY, 1'b1, 1'b0, 1'b0, f ? 2'h1 : 2'h2);
      if (f == 0) begin
        cpu_u.nmi(1'b1);
        wait_exc(PDM_CAUSE_NMI);
        cpu_u.nmi(1'b0);
        rd(PDM_CTRL_ADDR, 8'h9f);
      end else begin
        pin_reset();
        rd(PDM_CTRL_ADDR, 8'h1f);
      end
    end
    // Mid-run reset with both selects set: everything back to reset values
    wr(PDM_CTRL_ADDR, 8'hdf);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk_mode(PDM_RUN, 1'b0, 1'b1, 1'b0, 2'h0);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(PDM_CTRL_ADDR, PDM_CTRL_RST);
    print_verdict();
  end
endmodule
